// ### rtl/asio_port.sv
// serial port of the sampling converter: link logic on the serial clock,
// sequencer on the conversion clock (i_clk)
// assumes the host changes select and serial input while the serial clock is low
`timescale 1ns/1ps
module asio_port #(
  parameter int FIFO_DEPTH = 8,
  parameter int ACQ_N = asio_pkg::ACQ_CYCLES,
  parameter int CONVERT_N = asio_pkg::CONVERT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_serial_in,
  input wire logic i_program_enable_n,
  input wire logic [asio_pkg::RESULT_W-1:0] i_sample,
  output logic o_dout,
  output logic o_dout_oe_n,
  output logic o_eoc,
  output logic o_output_done_flag,
  output logic [asio_pkg::CHAN_W-1:0] o_channel,
  output logic [asio_pkg::MODE_W-1:0] o_mode
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic [asio_pkg::CNT_W-1:0] wlen_decode(
    input logic [1:0] sel, input logic [asio_pkg::CNT_W-1:0] cur);
    case (sel)
      asio_pkg::WLEN_SEL_SHORT: wlen_decode = asio_pkg::WLEN_RESET;
      asio_pkg::WLEN_SEL_LONG: wlen_decode = asio_pkg::WLEN_LONG;
      default: wlen_decode = cur;
    endcase
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic sclk_rst_n;
  logic cs_prev;
  logic [asio_pkg::CMD_W-1:0] in_shift;
  logic [asio_pkg::CNT_W-1:0] bit_cnt;
  logic [asio_pkg::CNT_W-1:0] wlen;
  logic done_flag;
  logic req_toggle;
  asio_pkg::asio_cmd_type cmd_hold;
  logic [asio_pkg::CMD_W-1:0] next_in_shift;
  logic [asio_pkg::CNT_W-1:0] next_bit_cnt;
  logic [asio_pkg::CNT_W-1:0] next_wlen;
  logic next_done_flag;
  logic next_req_toggle;
  asio_pkg::asio_cmd_type next_cmd_hold;
  logic [asio_pkg::CNT_W-1:0] eff_cnt;
  logic frame_end;

  logic started;
  logic [asio_pkg::OUT_W-1:0] out_shift;
  logic next_started;
  logic [asio_pkg::OUT_W-1:0] next_out_shift;
  logic [asio_pkg::OUT_W-1:0] result_ext;

  logic [1:0] pin_mid;
  logic [1:0] pin_late;
  logic tog_mid;
  logic tog_late;
  logic cs_filt;
  logic pe_filt;
  logic tog_seen;
  logic pend;
  asio_pkg::asio_cmd_type pend_cmd;
  logic next_cs_filt;
  logic next_pe_filt;
  logic next_tog_seen;
  logic next_pend;
  asio_pkg::asio_cmd_type next_pend_cmd;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  asio_pkg::asio_cmd_type fifo_out;

  asio_pkg::asio_seq_type seq;
  logic [asio_pkg::SEQ_CNT_W-1:0] seq_cnt;
  logic eoc;
  logic oe_n;
  logic [asio_pkg::RESULT_W-1:0] sample_cap;
  logic [asio_pkg::RESULT_W-1:0] result;
  asio_pkg::asio_cmd_type active_cmd;
  asio_pkg::asio_seq_type next_seq;
  logic [asio_pkg::SEQ_CNT_W-1:0] next_seq_cnt;
  logic next_eoc;
  logic next_oe_n;
  logic [asio_pkg::RESULT_W-1:0] next_sample_cap;
  logic [asio_pkg::RESULT_W-1:0] next_result;
  asio_pkg::asio_cmd_type next_active_cmd;

  // ----------------------------------------
  // serial clock domain: input side
  // ----------------------------------------
  // reset brought into link domain
  asio_sync #(.W(1)) u_sclk_rst (
    .i_clk(i_sclk),
    .i_d(i_rst_n),
    .o_mid(),
    .o_late(sclk_rst_n)
  );

  always_comb begin
    // a select that was high at the previous edge starts a fresh frame
    eff_cnt = cs_prev ? '0 : bit_cnt;
    next_in_shift = in_shift;
    next_bit_cnt = bit_cnt;
    next_wlen = wlen;
    next_done_flag = done_flag;
    next_req_toggle = req_toggle;
    next_cmd_hold = cmd_hold;
    frame_end = 1'b0;
    if (!i_cs_n) begin
      next_in_shift = {in_shift[asio_pkg::CMD_W-2:0], i_serial_in};
      next_bit_cnt = eff_cnt + 1'b1;
      if (eff_cnt == '0) begin
        next_done_flag = 1'b0;
      end
      if (eff_cnt + 1'b1 == wlen) begin
        frame_end = 1'b1;
        next_bit_cnt = '0;
        next_done_flag = 1'b1;
        if (!i_program_enable_n) begin
          next_cmd_hold = next_in_shift;
          next_req_toggle = ~req_toggle;
          next_wlen = wlen_decode(next_in_shift[1:0], wlen);
        end
      end
    end
  end

  always_ff @(posedge i_sclk) begin
    if (!sclk_rst_n) begin
      cs_prev <= 1'b1;
      in_shift <= '0;
      bit_cnt <= '0;
      wlen <= asio_pkg::WLEN_RESET;
      done_flag <= 1'b1;
      req_toggle <= 1'b0;
      cmd_hold <= asio_pkg::CMD_RESET;
    end else begin
      cs_prev <= i_cs_n;
      in_shift <= next_in_shift;
      bit_cnt <= next_bit_cnt;
      wlen <= next_wlen;
      done_flag <= next_done_flag;
      req_toggle <= next_req_toggle;
      cmd_hold <= next_cmd_hold;
    end
  end

  // ----------------------------------------
  // serial clock domain: output side
  // ----------------------------------------
  // result is quasi-static: it only changes after a frame's command ends
  assign result_ext = {result, {(asio_pkg::OUT_W-asio_pkg::RESULT_W){1'b0}}};

  always_comb begin
    next_started = started;
    next_out_shift = out_shift;
    if (!i_cs_n) begin
      if (bit_cnt == '0) begin
        next_started = 1'b0;
      end else if (!started) begin
        // first falling edge gives bit two
        next_out_shift = result_ext << 1;
        next_started = 1'b1;
      end else begin
        next_out_shift = out_shift << 1;
      end
    end
  end

  always_ff @(negedge i_sclk) begin
    if (!sclk_rst_n) begin
      started <= 1'b0;
      out_shift <= '0;
    end else begin
      started <= next_started;
      out_shift <= next_out_shift;
    end
  end

  // first bit shown before any edge
  assign o_dout = started ? out_shift[asio_pkg::OUT_W-1] : result[asio_pkg::RESULT_W-1];
  assign o_output_done_flag = done_flag;

  // ----------------------------------------
  // crossings into the conversion clock
  // ----------------------------------------
  // pins and request toggle synchronised
  asio_sync #(.W(2)) u_pin_sync (
    .i_clk(i_clk),
    .i_d({i_cs_n, i_program_enable_n}),
    .o_mid(pin_mid),
    .o_late(pin_late)
  );

  asio_sync #(.W(1)) u_tog_sync (
    .i_clk(i_clk),
    .i_d(req_toggle),
    .o_mid(tog_mid),
    .o_late(tog_late)
  );

  always_comb begin
    // a pin change counts only when stages two and three agree
    next_cs_filt = (pin_mid[1] == pin_late[1]) ? pin_late[1] : cs_filt;
    next_pe_filt = (pin_mid[0] == pin_late[0]) ? pin_late[0] : pe_filt;
    next_tog_seen = tog_late;
    next_pend = pend;
    next_pend_cmd = pend_cmd;
    if (pend && fifo_in_ready) begin
      next_pend = 1'b0;
    end
    // a new request wins over the handshake that clears the slot
    if ((tog_mid == tog_late) && (tog_late != tog_seen)) begin
      next_pend = 1'b1;
      next_pend_cmd = cmd_hold;
    end else begin
      next_tog_seen = tog_seen;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cs_filt <= 1'b1;
      pe_filt <= 1'b1;
      tog_seen <= 1'b0;
      pend <= 1'b0;
      pend_cmd <= asio_pkg::CMD_RESET;
    end else begin
      cs_filt <= next_cs_filt;
      pe_filt <= next_pe_filt;
      tog_seen <= next_tog_seen;
      pend <= next_pend;
      pend_cmd <= next_pend_cmd;
    end
  end

  // a full queue holds the pending command until a slot frees or a newer request replaces it
  asio_fifo #(.W(asio_pkg::CMD_W), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(pend),
    .o_in_ready(fifo_in_ready),
    .i_in_data(pend_cmd),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out)
  );

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  assign fifo_out_ready = (seq == asio_pkg::SEQ_IDLE)
    && !(cs_filt && !next_cs_filt && !next_pe_filt);
  always_comb begin
    next_seq = seq;
    next_seq_cnt = seq_cnt;
    next_eoc = eoc;
    next_sample_cap = sample_cap;
    next_result = result;
    next_active_cmd = active_cmd;
    next_oe_n = next_cs_filt;
    case (seq)
      asio_pkg::SEQ_IDLE: begin
        if (fifo_out_valid) begin
          next_active_cmd = fifo_out;
          next_seq = asio_pkg::SEQ_ACQUIRE;
          next_seq_cnt = asio_pkg::SEQ_CNT_W'(ACQ_N - 1);
          next_eoc = 1'b0;
        end
      end
      asio_pkg::SEQ_ACQUIRE: begin
        if (seq_cnt == '0) begin
          next_sample_cap = i_sample;
          next_seq = asio_pkg::SEQ_CONVERT;
          next_seq_cnt = asio_pkg::SEQ_CNT_W'(CONVERT_N - 1);
        end else begin
          next_seq_cnt = seq_cnt - 1'b1;
        end
      end
      asio_pkg::SEQ_CONVERT: begin
        if (seq_cnt == '0) begin
          next_result = sample_cap;
          next_eoc = 1'b1;
          next_seq = asio_pkg::SEQ_IDLE;
        end else begin
          next_seq_cnt = seq_cnt - 1'b1;
        end
      end
      default: begin
        next_seq = asio_pkg::SEQ_IDLE;
      end
    endcase
    if (cs_filt && !next_cs_filt && !next_pe_filt) begin
      next_seq = asio_pkg::SEQ_IDLE;
      next_seq_cnt = '0;
      next_eoc = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      seq <= asio_pkg::SEQ_IDLE;
      seq_cnt <= '0;
      eoc <= 1'b1;
      oe_n <= 1'b1;
      sample_cap <= '0;
      result <= '0;
      active_cmd <= asio_pkg::CMD_RESET;
    end else begin
      seq <= next_seq;
      seq_cnt <= next_seq_cnt;
      eoc <= next_eoc;
      oe_n <= next_oe_n;
      sample_cap <= next_sample_cap;
      result <= next_result;
      active_cmd <= next_active_cmd;
    end
  end

  assign o_eoc = eoc;
  assign o_dout_oe_n = oe_n;
  assign o_channel = active_cmd.channel;
  assign o_mode = active_cmd.mode;
endmodule // asio_port

// ### common/asio_pkg.sv
// shared constants and carrier types for the converter serial port
// assumes one serial clock from the host and one conversion clock (i_clk)
// What this block does
// - select low: rising edge shifts serial input
// - falling edges shift out later result bits
// - continuous select: first bit at conversion done
// - toggled select: select fall gives first bit
// - select fall with program enable low aborts conversion, restarts sequence
// - power-up word length is thirteen clocks
// - clocks per transfer equal programmed length
// - output done low while shifting, then high
// - shifted word selects channel and mode
// - conversion clock times acquire and convert
// - serial clock paces all serial exchange
// - conversion done low while busy, rises after
// - program enable high: read only, no conversion
// - output driven with select low, released high
package asio_pkg;
  // ----------------------------------------
  // command word shifted in by the host
  // ----------------------------------------
  localparam int CMD_W = 8;
  localparam int CHAN_W = 4;
  localparam int MODE_W = 4;
  typedef struct packed {
    logic [CHAN_W-1:0] channel;
    logic [MODE_W-1:0] mode;
  } asio_cmd_type;
  localparam asio_cmd_type CMD_RESET = '{channel: 4'h0, mode: 4'h0};

  // ----------------------------------------
  // word length and result layout
  // ----------------------------------------
  localparam int CNT_W = 5;
  localparam int RESULT_W = 13;
  localparam int OUT_W = 17;
  localparam logic [CNT_W-1:0] WLEN_RESET = 5'h0d;
  localparam logic [CNT_W-1:0] WLEN_LONG = 5'h11;
  localparam logic [1:0] WLEN_SEL_SHORT = 2'h0;
  localparam logic [1:0] WLEN_SEL_LONG = 2'h1;

  // ----------------------------------------
  // sequencer timing in conversion clocks
  // ----------------------------------------
  localparam int ACQ_CYCLES = 10;
  localparam int CONVERT_CYCLES = 44;
  localparam int SEQ_CNT_W = 6;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ACQUIRE,
    SEQ_CONVERT
  } asio_seq_type;
endpackage

// ### rtl/asio_sync.sv
// three-stage synchroniser for levels entering a clock domain
// assumes inputs are levels or toggles that stay put for several destination clocks
`timescale 1ns/1ps
module asio_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_mid,
  output logic [W-1:0] o_late
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_stage2;
  logic [W-1:0] next_stage3;

  always_comb begin
    next_stage1 = i_d;
    next_stage2 = stage1;
    next_stage3 = stage2;
  end

  // no reset: the chain flushes within three edges
  always_ff @(posedge i_clk) begin
    stage1 <= next_stage1;
    stage2 <= next_stage2;
    stage3 <= next_stage3;
  end

  assign o_mid = stage2;
  assign o_late = stage3;
endmodule // asio_sync

// ### rtl/asio_fifo.sv
// synchronous FIFO with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module asio_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [PW:0] next_count;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_count = count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  assign o_in_ready = (count != (PW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
endmodule // asio_fifo

// ### dv/asio_port_assertions.sv
// checker for the converter serial port, bound into every asio_port
// assumes the bind hands on the sequencer lengths of the instance
`timescale 1ns/1ps
module asio_chk #(
  parameter int ACQ_N = 10,
  parameter int CONVERT_N = 44
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_program_enable_n,
  input wire logic o_dout_oe_n,
  input wire logic o_eoc,
  input wire logic o_output_done_flag,
  input wire logic [asio_pkg::CHAN_W-1:0] o_channel,
  input wire logic [asio_pkg::MODE_W-1:0] o_mode
);
  localparam int BUSY = ACQ_N + CONVERT_N;
  // ------------------------------
  // assertions
  // ------------------------------
  // idle after reset
  a_reset_idle: assert property (
    @(posedge i_clk) !i_rst_n |=> o_eoc && o_dout_oe_n) else $error("not idle after reset");
  a_oe_drive: assert property (
    @(posedge i_clk) disable iff (!i_rst_n) !i_cs_n [*8] |-> !o_dout_oe_n)
    else $error("output not driven while selected");
  a_oe_release: assert property (
    @(posedge i_clk) disable iff (!i_rst_n) i_cs_n [*8] |-> o_dout_oe_n)
    else $error("output driven while deselected");
  a_oe_cause: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_dout_oe_n) |-> !$past(i_cs_n, 3) && !$past(i_cs_n))
    else $error("output enabled without select");
  a_busy_span: assert property (
    @(posedge i_clk) disable iff (!i_rst_n) $rose(o_eoc) |-> !$past(o_eoc, BUSY))
    else $error("conversion shorter than acquire plus convert");
  a_abort_busy: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $fell(i_cs_n) && !i_program_enable_n |-> ##[1:10] !o_eoc)
    else $error("select fall did not restart the sequence");
  a_cmd_busy: assert property (
    @(posedge i_clk) disable iff (!i_rst_n) !$stable({o_channel, o_mode}) |-> !o_eoc)
    else $error("channel or mode changed while idle");
  a_frame_len: assert property (
    @(posedge i_sclk) disable iff (!i_rst_n)
    $rose(o_output_done_flag) |-> !$past(o_output_done_flag, 12))
    else $error("done flag rose before the word was out");
  c_convert_end: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_eoc));
  c_abort: cover property (@(posedge i_clk) disable iff (!i_rst_n) $fell(i_cs_n) && !o_eoc);
  c_frame: cover property (@(posedge i_sclk) disable iff (!i_rst_n) $rose(o_output_done_flag));
endmodule // asio_chk

bind asio_port asio_chk #(.ACQ_N(ACQ_N), .CONVERT_N(CONVERT_N)) i_chk (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
  .i_program_enable_n(i_program_enable_n), .o_dout_oe_n(o_dout_oe_n), .o_eoc(o_eoc),
  .o_output_done_flag(o_output_done_flag), .o_channel(o_channel), .o_mode(o_mode));

// ### dv/asio_host_model.sv
// host side of the serial link: select, serial clock and serial input
// assumes its tasks are called one at a time from the bench
`timescale 1ns/1ps
module asio_host_model (
  input wire logic i_clk,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_serial_in,
  input wire logic i_dout
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_serial_in = 1'b0;
  end
  // ------------------------------
  // link tasks
  // ------------------------------
  // reset needs a running link clock, so pulses are given outside frames
  task automatic pulses(input int n);
    for (int k = 0; k < n; k++) begin
      #3 o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
    end
  endtask
  task automatic frame(input logic [16:0] tx, input int n, input bit hold,
                       output logic [16:0] rx);
    rx = '0;
    // select falls with clock low
    // a high phase of one clock would be swallowed by the pin filter, so no abort
    if (o_cs_n) begin
      repeat (4) @(negedge i_clk);
      o_cs_n = 1'b0;
    end
    #301.3;
    for (int k = n - 1; k >= 0; k--) begin
      o_serial_in = tx[k];
      #3 rx[k] = i_dout;
      o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
    end
    o_serial_in = ~o_serial_in;
    #300;
    if (!hold) begin
      @(negedge i_clk);
      o_cs_n = 1'b1;
    end
  endtask
endmodule // asio_host_model

// ### dv/tb_adc_serial_io_port.sv
// self-checking bench for the converter serial port
// assumes the bound checker and the host model beside it
`timescale 1ns/1ps
`define CHK(got, exp, what) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("CHECK FAILED t=%0t %s", $time, what); \
    end \
  end
module tb_adc_serial_io_port;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pe_n = 1'b0;
  logic [asio_pkg::RESULT_W-1:0] sample = 13'h1a5c;
  logic sclk, cs_n, din, dout, dout_oe_n, eoc, done_flag, dline, eoc_q;
  logic [3:0] chan, mode;
  logic [3:0] done_ch[$];
  logic [16:0] rx;
  int n_errors = 0;
  int n_tests = 0;
  assign dline = dout_oe_n ? 1'bz : dout;
  always #20 clk = ~clk;
  asio_host_model i_host (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_serial_in(din),
    .i_dout(dline));
  // long conversions so that queued commands pile up behind a busy sequencer;
  // each phase must still fit the six-bit sequencer counter
  asio_port #(.FIFO_DEPTH(8), .ACQ_N(10), .CONVERT_N(60)) i_dut (.i_clk(clk), .i_rst_n(rst_n),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_serial_in(din), .i_program_enable_n(pe_n),
    .i_sample(sample), .o_dout(dout), .o_dout_oe_n(dout_oe_n), .o_eoc(eoc),
    .o_output_done_flag(done_flag), .o_channel(chan), .o_mode(mode));
  // sampled on the falling edge so that flop outputs have settled
  always @(negedge clk) begin
    eoc_q <= eoc;
    if (eoc === 1'b1 && eoc_q === 1'b0) done_ch.push_back(chan);
  end
  // ------------------------------
  // helpers
  // ------------------------------
  function automatic logic [16:0] cmd(input logic [3:0] ch, input logic [3:0] md);
    return {9'h000, asio_pkg::asio_cmd_type'{channel: ch, mode: md}};
  endfunction
  task automatic wait_eoc();
    for (int k = 0; k < 400 && eoc !== 1'b1; k++) @(negedge clk);
    `CHK(eoc, 1'b1, "conversion did not end")
    repeat (2) @(negedge clk);
  endtask
  task automatic finish_test();
    $display("n_errors %0d n_tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_power_up();
    i_host.frame(cmd(4'h5, 4'h0), 13, 1'b0, rx);
    `CHK(done_flag, 1'b1, "done flag after word")
    `CHK(eoc, 1'b0, "busy during conversion")
    wait_eoc();
    `CHK({chan, mode}, 8'h50, "channel and mode")
    i_host.frame(cmd(4'h5, 4'h0), 13, 1'b0, rx);
    `CHK(rx[12:0], 13'h1a5c, "first result")
    wait_eoc();
  endtask
  task automatic t_word_length();
    i_host.frame(cmd(4'h3, 4'h1), 13, 1'b0, rx);
    wait_eoc();
    i_host.frame(cmd(4'h3, 4'h0), 17, 1'b0, rx);
    `CHK(rx, 17'h1a5c0, "long word")
    wait_eoc();
    i_host.frame(cmd(4'h3, 4'h0), 13, 1'b0, rx);
    `CHK(rx[12:0], 13'h1a5c, "short word again")
    wait_eoc();
  endtask
  task automatic t_read_only();
    pe_n = 1'b1;
    sample = 13'h0333;
    repeat (8) @(negedge clk);
    i_host.frame(cmd(4'h7, 4'h1), 13, 1'b0, rx);
    `CHK(rx[12:0], 13'h1a5c, "stored result")
    repeat (100) @(negedge clk);
    `CHK(eoc, 1'b1, "no conversion")
    `CHK({chan, mode}, 8'h30, "configuration kept")
    i_host.frame(cmd(4'h7, 4'h0), 13, 1'b0, rx);
    `CHK(rx[12:0], 13'h1a5c, "length kept")
    pe_n = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic t_abort();
    sample = 13'h0aaa;
    done_ch.delete();
    i_host.frame(cmd(4'h1, 4'h0), 13, 1'b0, rx);
    // result read during a conversion is discarded
    i_host.frame(cmd(4'h2, 4'h0), 13, 1'b0, rx);
    wait_eoc();
    `CHK(done_ch.size(), 1, "aborted conversion finished")
    `CHK(chan, 4'h2, "restarted command")
    i_host.frame(cmd(4'h2, 4'h0), 13, 1'b0, rx);
    `CHK(rx[12:0], 13'h0aaa, "result after restart")
    wait_eoc();
  endtask
  task automatic t_continuous();
    sample = 13'h1234;
    i_host.frame(cmd(4'h4, 4'h0), 13, 1'b1, rx);
    wait_eoc();
    i_host.frame(cmd(4'h4, 4'h0), 13, 1'b0, rx);
    `CHK(rx[12:0], 13'h1234, "first bit at conversion end")
    wait_eoc();
  endtask
  task automatic t_fifo_fill();
    done_ch.delete();
    for (int c = 1; c <= 14; c++) begin
      i_host.frame(cmd(c[3:0], 4'h0), 13, c < 14, rx);
    end
    for (int k = 0; k < 1500 && (done_ch.size() == 0 || done_ch[$] !== 4'he); k++) begin
      @(negedge clk);
    end
    `CHK(done_ch.size() inside {[10:13]}, 1'b1, "queue did not refuse")
    for (int k = 1; k < done_ch.size(); k++) begin
      `CHK(done_ch[k] > done_ch[k-1], 1'b1, "command order")
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    @(negedge clk);
    i_host.pulses(8);
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    i_host.pulses(6);
    repeat (4) @(negedge clk);
    t_power_up();
    t_word_length();
    t_read_only();
    t_abort();
    t_continuous();
    t_fifo_fill();
    finish_test();
  end
endmodule // tb_adc_serial_io_port
